/* dv/sid_scan_controller.sv */
// Behavioural boundary-scan controller that walks the TAP states and clocks the link.
`timescale 1ns/1ns

module sid_scan_controller (
  output logic tck,
  output logic test_logic_reset,
  output logic capture_ir,
  output logic shift_ir,
  output logic update_ir,
  output logic capture_dr,
  output logic shift_dr,
  output logic run_idle,
  output logic tdi,
  input wire logic ir_tdo,
  input wire logic dr_tdo
);
  initial begin
    tck = 1'h0;
    {test_logic_reset, capture_ir, shift_ir, update_ir, capture_dr, shift_dr, run_idle} = 7'h00;
    tdi = 1'h0;
  end

  // One 125 ns link period; the link clock stands low between steps.
  task automatic step(input logic [6:0] st, input logic d);
    {test_logic_reset, capture_ir, shift_ir, update_ir, capture_dr, shift_dr, run_idle} = st;
    // Outside a shift the serial line flips, so a stale bit cannot pass for data.
    tdi = (st[4] | st[1]) ? d : ~tdi;
    #63 tck = 1'h1;
    #62 tck = 1'h0;
  endtask : step

  task automatic reset_logic();
    step(7'h40, 1'h0);
    step(7'h00, 1'h0);
  endtask : reset_logic

  // Eight bits out, least significant first; the captured value returns the same way.
  task automatic load_ir(input logic [7:0] op, output logic [7:0] cap);
    step(7'h20, 1'h0);
    for (int i = 0; i < 8; i++) begin
      step(7'h10, op[i]);
      cap[i] = ir_tdo;
    end
    step(7'h08, 1'h0);
    step(7'h00, 1'h0);
  endtask : load_ir

  task automatic scan_dr(input int n, input logic [2:0] din, output logic [2:0] dout);
    dout = 3'h0;
    step(7'h04, 1'h0);
    for (int i = 0; i < n; i++) begin
      step(7'h02, din[i]);
      dout[i] = dr_tdo;
    end
    step(7'h00, 1'h0);
  endtask : scan_dr

endmodule : sid_scan_controller

/* dv/tb.sv */
// Self-checking testbench for the scan instruction decoder.
`timescale 1ns/1ns

module tb;
  import sid_pkg::*;
  logic clock, rst, clock_en, ab_en_n, ba_en_n;
  logic tck, tlr, cir, sir, uir, cdr, sdr, ri, tdi, ir_tdo, dr_tdo;
  sid_sel_e data_select;
  sid_cap_e boundary_capture;
  sid_run_e run_op;
  logic test_mode, io_highz, a_out, b_out, p2c, hold, tog, run_active, sys_tm, sys_hz;
  logic [7:0] cap;
  logic [2:0] dout;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  sid_scan_instruction_decoder i_sid_scan_instruction_decoder (.clock(clock), .rst(rst),
    .clock_en(clock_en), .tck(tck), .test_logic_reset(tlr), .capture_ir(cir),
    .shift_ir(sir), .update_ir(uir), .capture_dr(cdr), .shift_dr(sdr), .run_idle(ri),
    .tdi(tdi), .a_to_b_drive_enable_n(ab_en_n), .b_to_a_drive_enable_n(ba_en_n),
    .ir_tdo(ir_tdo), .dr_tdo(dr_tdo), .data_select(data_select), .test_mode(test_mode),
    .io_highz(io_highz), .a_pins_output(a_out), .b_pins_output(b_out), .pins_to_core(p2c),
    .boundary_capture(boundary_capture), .input_cells_hold(hold), .toggle_active(tog),
    .run_active(run_active), .run_op(run_op), .sys_test_mode(sys_tm), .sys_io_highz(sys_hz));

  sid_scan_controller i_sid_scan_controller (.tck(tck), .test_logic_reset(tlr),
    .capture_ir(cir), .shift_ir(sir), .update_ir(uir), .capture_dr(cdr), .shift_dr(sdr),
    .run_idle(ri), .tdi(tdi), .ir_tdo(ir_tdo), .dr_tdo(dr_tdo));

  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  // A hung handshake must still end in the closing report.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic set_oe(input logic ab, input logic ba);
    @(negedge clock);
    ab_en_n = ab;
    ba_en_n = ba;
    #1;
  endtask : set_oe

  task automatic ir(input logic [7:0] op);
    i_sid_scan_controller.load_ir(op, cap);
    chk("ir capture", IR_CAPTURE, cap);
  endtask : ir

  task automatic t_op(input logic [7:0] op, input sid_sel_e sel, input logic tm,
                      input logic hz, input logic pc, input sid_cap_e cp, input logic hd);
    ir(op);
    chk("data_select", sel, data_select);
    chk("test_mode", tm, test_mode);
    chk("io_highz", hz, io_highz);
    chk("pins_to_core", pc, p2c);
    chk("input_cells_hold", hd, hold);
    if (sel == SEL_BOUNDARY) chk("boundary_capture", cp, boundary_capture);
  endtask : t_op

  task automatic t_table();
    t_op(OPC_BOUNDARY_SCAN, SEL_BOUNDARY, 1'h1, 1'h0, 1'h1, CAP_PINS, 1'h0);
    t_op(OPC_IDENT_READ, SEL_IDENT, 1'h0, 1'h0, 1'h0, CAP_PINS, 1'h0);
    t_op(OPC_SAMPLE_BOUNDARY, SEL_BOUNDARY, 1'h0, 1'h0, 1'h0, CAP_SAMPLE, 1'h0);
    t_op(8'h03, SEL_BYPASS, 1'h0, 1'h0, 1'h0, CAP_PINS, 1'h0);
    t_op(8'h84, SEL_BYPASS, 1'h0, 1'h0, 1'h0, CAP_PINS, 1'h0);
    t_op(8'h05, SEL_BYPASS, 1'h0, 1'h0, 1'h0, CAP_PINS, 1'h0);
    t_op(8'h88, SEL_BYPASS, 1'h0, 1'h0, 1'h0, CAP_PINS, 1'h0);
    t_op(8'hff, SEL_BYPASS, 1'h0, 1'h0, 1'h0, CAP_PINS, 1'h0);
    t_op(OPC_HIGH_IMPEDANCE, SEL_BYPASS, 1'h0, 1'h1, 1'h0, CAP_PINS, 1'h0);
    t_op(OPC_CLAMP_BOUNDARY, SEL_BYPASS, 1'h1, 1'h0, 1'h0, CAP_PINS, 1'h0);
    t_op(OPC_BOUNDARY_RUN, SEL_BYPASS, 1'h1, 1'h0, 1'h0, CAP_PINS, 1'h0);
    t_op(OPC_READ_NORMAL, SEL_BOUNDARY, 1'h0, 1'h0, 1'h0, CAP_HOLD, 1'h0);
    t_op(OPC_READ_TEST, SEL_BOUNDARY, 1'h1, 1'h0, 1'h0, CAP_HOLD, 1'h0);
    t_op(OPC_CELL_SELF_TEST, SEL_BOUNDARY, 1'h0, 1'h0, 1'h0, CAP_INVERT, 1'h0);
    t_op(OPC_TOGGLE_OUTPUTS, SEL_BYPASS, 1'h1, 1'h0, 1'h0, CAP_PINS, 1'h1);
    t_op(OPC_CONTROL_SCAN_NORMAL, SEL_CONTROL, 1'h0, 1'h0, 1'h0, CAP_PINS, 1'h0);
    t_op(OPC_CONTROL_SCAN_TEST, SEL_CONTROL, 1'h1, 1'h0, 1'h0, CAP_PINS, 1'h0);
  endtask : t_table

  // Captured zero comes out first, then the bit shifted in behind it.
  task automatic t_bypass();
    logic [7:0] ops [5];
    ops = '{8'h03, OPC_HIGH_IMPEDANCE, OPC_CLAMP_BOUNDARY, OPC_BOUNDARY_RUN, OPC_TOGGLE_OUTPUTS};
    foreach (ops[k]) begin
      ir(ops[k]);
      i_sid_scan_controller.scan_dr(2, 3'h3, dout);
      chk("bypass out", 8'h02, dout);
    end
  endtask : t_bypass

  task automatic t_control();
    ir(OPC_CONTROL_SCAN_NORMAL);
    i_sid_scan_controller.scan_dr(3, 3'h7, dout);
    chk("run select reset", CONTROL_RESET, dout);
    i_sid_scan_controller.scan_dr(3, 3'h5, dout);
    chk("run select hold", 8'h07, dout);
    i_sid_scan_controller.reset_logic();
    chk("reset select", SEL_IDENT, data_select);
    ir(OPC_CONTROL_SCAN_TEST);
    i_sid_scan_controller.scan_dr(3, 3'h0, dout);
    chk("run select rereset", CONTROL_RESET, dout);
  endtask : t_control

  task automatic t_run();
    sid_run_e exp_op [8];
    exp_op = '{RUN_TOGGLE_SAMPLE, RUN_PATTERN, RUN_SIGNATURE, RUN_SIG_PATTERN,
      RUN_TOGGLE_SAMPLE, RUN_PATTERN, RUN_SIGNATURE, RUN_SIG_COUNT};
    for (int v = 0; v < 8; v++) begin
      ir(OPC_CONTROL_SCAN_NORMAL);
      i_sid_scan_controller.scan_dr(3, v[2:0], dout);
      ir(OPC_BOUNDARY_RUN);
      repeat (2) i_sid_scan_controller.step(7'h01, 1'h0);
      chk("run_active", 8'h01, run_active);
      chk("run_op", exp_op[v], run_op);
    end
    set_oe(1'h1, 1'h1);
    chk("demoted run_active", 8'h00, run_active);
    chk("demoted test_mode", 8'h00, test_mode);
    chk("demoted run_op", RUN_NONE, run_op);
    set_oe(1'h0, 1'h1);
    ir(OPC_TOGGLE_OUTPUTS);
    i_sid_scan_controller.step(7'h01, 1'h0);
    chk("toggle_active", 8'h01, tog);
    i_sid_scan_controller.step(7'h00, 1'h0);
    chk("toggle idle", 8'h00, tog);
  endtask : t_run

  task automatic t_direction();
    ir(OPC_BOUNDARY_SCAN);
    chk("b pins out", 8'h01, b_out);
    chk("a pins in", 8'h00, a_out);
    set_oe(1'h1, 1'h0);
    chk("a pins out", 8'h01, a_out);
    chk("b pins in", 8'h00, b_out);
  endtask : t_direction

  // The system copies of the mode lag by a few clocks and freeze while disabled.
  task automatic t_sys();
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk("sys_test_mode", 8'h01, sys_tm);
    @(negedge clock) clock_en = 1'h0;
    ir(OPC_HIGH_IMPEDANCE);
    chk("sys frozen", 8'h01, sys_tm);
    @(negedge clock) clock_en = 1'h1;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk("sys_test_mode off", 8'h00, sys_tm);
    chk("sys_io_highz", 8'h01, sys_hz);
  endtask : t_sys

  initial begin
    rst = 1'h1;
    clock_en = 1'h0;
    ab_en_n = 1'h0;
    ba_en_n = 1'h1;
    repeat (6) @(posedge clock);
    @(negedge clock) rst = 1'h0;
    i_sid_scan_controller.reset_logic();
    // The system copies stay frozen until the scan side has left its unknown power-up state.
    @(negedge clock) clock_en = 1'h1;
    t_control();
    t_table();
    t_bypass();
    t_run();
    t_direction();
    t_sys();
    summarize();
  end

endmodule : tb

/* inc/sid_pkg.sv */
// Constants, opcodes and types shared by the scan instruction decoder.
package sid_pkg;

  localparam int IR_WIDTH = 8;
  localparam int CONTROL_WIDTH = 3;

  // Value loaded into the instruction shift stage at Capture-IR.
  localparam logic [7:0] IR_CAPTURE = 8'h01;

  // Active instruction after Test-Logic-Reset.
  localparam logic [7:0] IR_RESET = 8'h81;

  // Run-select register value after Test-Logic-Reset.
  localparam logic [2:0] CONTROL_RESET = 3'h2;

  localparam logic [7:0] OPC_BOUNDARY_SCAN = 8'h00;
  localparam logic [7:0] OPC_IDENT_READ = 8'h81;
  localparam logic [7:0] OPC_SAMPLE_BOUNDARY = 8'h82;
  localparam logic [7:0] OPC_HIGH_IMPEDANCE = 8'h06;
  localparam logic [7:0] OPC_CLAMP_BOUNDARY = 8'h87;
  localparam logic [7:0] OPC_BOUNDARY_RUN = 8'h09;
  localparam logic [7:0] OPC_READ_NORMAL = 8'h0a;
  localparam logic [7:0] OPC_READ_TEST = 8'h8b;
  localparam logic [7:0] OPC_CELL_SELF_TEST = 8'h0c;
  localparam logic [7:0] OPC_TOGGLE_OUTPUTS = 8'h8d;
  localparam logic [7:0] OPC_CONTROL_SCAN_NORMAL = 8'h8e;
  localparam logic [7:0] OPC_CONTROL_SCAN_TEST = 8'h0f;

  typedef enum logic [1:0] {
    SEL_BOUNDARY, SEL_IDENT, SEL_BYPASS, SEL_CONTROL
  } sid_sel_e;

  typedef enum logic [1:0] {
    CAP_PINS, CAP_SAMPLE, CAP_HOLD, CAP_INVERT
  } sid_cap_e;

  typedef enum logic [2:0] {
    RUN_NONE, RUN_TOGGLE_SAMPLE, RUN_PATTERN, RUN_SIGNATURE, RUN_SIG_PATTERN, RUN_SIG_COUNT
  } sid_run_e;

  typedef struct packed {
    sid_sel_e sel;
    logic test;
    logic highz;
    logic drive;
    logic forward;
    sid_cap_e cap;
    logic run;
    logic toggle;
  } sid_dec_s;

endpackage : sid_pkg

/* src/sid_scan_instruction_decoder.sv */
// Instruction register, decoder, bypass and run-select registers of the scan test logic.
// Function
// - Eight-bit instructions; every defined opcode has even parity.
// - Opcode 00000000: boundary register, test mode, pins captured, output cells driven.
// - Boundary scan forwards all pins except output enables to core logic.
// - Enable cells 47 and 46 at zero put their pins in output mode.
// - Opcode 10000001 selects identification register, normal mode.
// - Opcode 10000010: boundary register, normal mode, output cells capture core logic.
// - Listed bypass opcodes and all undefined codes select bypass, normal mode.
// - Selected bypass register captures zero at Capture-DR.
// - Opcode 00000110: bypass, all I/O pins high impedance, core keeps working.
// - Opcode 10000111: bypass, test mode, output cells drive the pins.
// - Opcode 00001001: bypass, test mode, run operation in Run-Test/Idle.
// - Opcodes 00001010 and 10001011 select boundary register, hold at capture.
// - Opcode 00001100: boundary register, normal mode, cells capture their inverse.
// - Opcode 10001101: bypass, test mode, output cells toggle in Run-Test/Idle.
// - During toggle outputs, input-mode cells hold and do not sample.
// - Opcodes 10001110 and 00001111 select the three-bit run-select register.
// - Run-select register resets to 010 and holds at Capture-DR.
// - Run-select bits decode toggle, pattern, signature, signature-pattern, signature-count.
// - Run operations need opposite enable directions, otherwise bypass behaviour.
`timescale 1ns/1ns

module sid_scan_instruction_decoder
  import sid_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic tck,
  input wire logic test_logic_reset,
  input wire logic capture_ir,
  input wire logic shift_ir,
  input wire logic update_ir,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic run_idle,
  input wire logic tdi,
  input wire logic a_to_b_drive_enable_n,
  input wire logic b_to_a_drive_enable_n,
  output logic ir_tdo,
  output logic dr_tdo,
  output sid_sel_e data_select,
  output logic test_mode,
  output logic io_highz,
  output logic a_pins_output,
  output logic b_pins_output,
  output logic pins_to_core,
  output sid_cap_e boundary_capture,
  output logic input_cells_hold,
  output logic toggle_active,
  output logic run_active,
  output sid_run_e run_op,
  output logic sys_test_mode,
  output logic sys_io_highz
);

  // Decode of one opcode; anything not listed falls through to bypass in normal mode.
  function automatic sid_dec_s sid_decode(input logic [7:0] op);
    sid_dec_s d;
    d = '{sel: SEL_BYPASS, test: 1'b0, highz: 1'b0, drive: 1'b0, forward: 1'b0,
          cap: CAP_HOLD, run: 1'b0, toggle: 1'b0};
    case (op)
      OPC_BOUNDARY_SCAN: begin
        d.sel = SEL_BOUNDARY;
        d.test = 1'b1;
        d.drive = 1'b1;
        d.forward = 1'b1;
        d.cap = CAP_PINS;
      end
      OPC_IDENT_READ: begin
        d.sel = SEL_IDENT;
      end
      OPC_SAMPLE_BOUNDARY: begin
        d.sel = SEL_BOUNDARY;
        d.cap = CAP_SAMPLE;
      end
      OPC_HIGH_IMPEDANCE: begin
        d.highz = 1'b1;
      end
      OPC_CLAMP_BOUNDARY: begin
        d.test = 1'b1;
        d.drive = 1'b1;
      end
      OPC_BOUNDARY_RUN: begin
        d.test = 1'b1;
        d.drive = 1'b1;
        d.run = 1'b1;
      end
      OPC_READ_NORMAL: begin
        d.sel = SEL_BOUNDARY;
      end
      OPC_READ_TEST: begin
        d.sel = SEL_BOUNDARY;
        d.test = 1'b1;
        d.drive = 1'b1;
      end
      OPC_CELL_SELF_TEST: begin
        d.sel = SEL_BOUNDARY;
        d.cap = CAP_INVERT;
      end
      OPC_TOGGLE_OUTPUTS: begin
        d.test = 1'b1;
        d.drive = 1'b1;
        d.toggle = 1'b1;
      end
      OPC_CONTROL_SCAN_NORMAL: begin
        d.sel = SEL_CONTROL;
      end
      OPC_CONTROL_SCAN_TEST: begin
        d.sel = SEL_CONTROL;
        d.test = 1'b1;
        d.drive = 1'b1;
      end
      default: begin
        d.sel = SEL_BYPASS;
      end
    endcase
    return d;
  endfunction : sid_decode

  logic [IR_WIDTH-1:0] ir_shift;
  logic [IR_WIDTH-1:0] active_instr;
  sid_dec_s dec;
  logic bypass_bit;
  logic [CONTROL_WIDTH-1:0] run_select_register;
  logic test_meta;
  logic test_sync;
  logic highz_meta;
  logic highz_sync;

  // Instruction shift stage; it never steers the block until Update-IR.
  always_ff @(posedge tck) begin
    if (capture_ir) begin
      ir_shift <= IR_CAPTURE;
    end else if (shift_ir) begin
      ir_shift <= {tdi, ir_shift[IR_WIDTH-1:1]};
    end
  end

  // Active instruction and its decode change only here.
  always_ff @(posedge tck) begin
    if (test_logic_reset) begin
      active_instr <= IR_RESET;
      dec <= sid_decode(IR_RESET);
    end else if (update_ir) begin
      active_instr <= ir_shift;
      dec <= sid_decode(ir_shift);
    end
  end

  always_ff @(posedge tck) begin
    if (test_logic_reset) begin
      bypass_bit <= 1'b0;
    end else if (capture_dr && dec.sel == SEL_BYPASS) begin
      bypass_bit <= 1'b0;
    end else if (shift_dr && dec.sel == SEL_BYPASS) begin
      bypass_bit <= tdi;
    end
  end

  // Capture-DR leaves this register untouched, so a chosen operation survives scans.
  always_ff @(posedge tck) begin
    if (test_logic_reset) begin
      run_select_register <= CONTROL_RESET;
    end else if (shift_dr && dec.sel == SEL_CONTROL) begin
      run_select_register <= {tdi, run_select_register[CONTROL_WIDTH-1:1]};
    end
  end

  always_ff @(posedge tck) begin
    if (test_logic_reset) begin
      ir_tdo <= 1'b0;
      dr_tdo <= 1'b0;
    end else begin
      ir_tdo <= ir_shift[0];
      dr_tdo <= (dec.sel == SEL_CONTROL) ? run_select_register[0] : bypass_bit;
    end
  end

  wire logic dir_opposite = a_to_b_drive_enable_n != b_to_a_drive_enable_n;
  // A run instruction with both directions alike behaves as plain bypass.
  wire logic run_demoted = dec.run && !dir_opposite;
  wire logic sig_count = run_select_register[2];
  wire sid_run_e run_decoded =
    (run_select_register[1:0] == 2'h0) ? RUN_TOGGLE_SAMPLE :
    (run_select_register[1:0] == 2'h1) ? RUN_PATTERN :
    (run_select_register[1:0] == 2'h2) ? RUN_SIGNATURE :
    (sig_count ? RUN_SIG_COUNT : RUN_SIG_PATTERN);

  assign data_select = dec.sel;
  assign test_mode = dec.test && !run_demoted;
  assign io_highz = dec.highz;
  assign a_pins_output = test_mode && dec.drive && !b_to_a_drive_enable_n;
  assign b_pins_output = test_mode && dec.drive && !a_to_b_drive_enable_n;
  assign pins_to_core = dec.forward;
  assign boundary_capture = dec.cap;
  assign input_cells_hold = dec.toggle;
  assign toggle_active = dec.toggle && run_idle;
  assign run_active = dec.run && dir_opposite && run_idle;
  assign run_op = run_active ? run_decoded : RUN_NONE;

  // Mode levels handed to the transceiver logic on the system clock.
  always_ff @(posedge clock) begin
    if (rst) begin
      test_meta <= 1'b0;
      test_sync <= 1'b0;
      highz_meta <= 1'b0;
      highz_sync <= 1'b0;
    end else if (clock_en) begin
      test_meta <= test_mode;
      test_sync <= test_meta;
      highz_meta <= io_highz;
      highz_sync <= highz_meta;
    end
  end

  assign sys_test_mode = test_sync;
  assign sys_io_highz = highz_sync;

  wire logic dec_is_bypass = dec.sel == SEL_BYPASS && !dec.test && !dec.highz;

  chk_defined_parity: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    !dec_is_bypass |-> (^active_instr) == 1'b0)
    else $error("defined instruction has odd parity");

  chk_update_loads: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    update_ir |=> active_instr == $past(ir_shift))
    else $error("instruction not loaded at update");

  chk_boundary_scan: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    active_instr == OPC_BOUNDARY_SCAN |->
      data_select == SEL_BOUNDARY && test_mode && boundary_capture == CAP_PINS && pins_to_core)
    else $error("boundary scan decode wrong");

  chk_ident_normal: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    active_instr == OPC_IDENT_READ |-> data_select == SEL_IDENT && !test_mode)
    else $error("identification decode wrong");

  chk_bypass_zero: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    capture_dr && data_select == SEL_BYPASS |=> !bypass_bit ##1 (dr_tdo == 1'b0))
    else $error("bypass did not capture zero");

  chk_control_reset: assert property (
    @(posedge tck)
    test_logic_reset |=> run_select_register == CONTROL_RESET)
    else $error("run select register reset value wrong");

  chk_control_hold: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    capture_dr && !shift_dr |=> $stable(run_select_register))
    else $error("run select register changed at capture");

  chk_run_direction: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    run_active |-> a_to_b_drive_enable_n != b_to_a_drive_enable_n && test_mode)
    else $error("run active with equal directions");

  chk_highz_mode: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    active_instr == OPC_HIGH_IMPEDANCE |->
      io_highz && !test_mode && !a_pins_output && !b_pins_output)
    else $error("high impedance decode wrong");

  chk_toggle_hold: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    toggle_active |-> input_cells_hold && boundary_capture == CAP_HOLD && test_mode)
    else $error("input cells not held while toggling");

  chk_undefined_bypass: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    update_ir && ir_shift == 8'h03 |=> data_select == SEL_BYPASS && !test_mode)
    else $error("undefined opcode not bypass");

  // Two enabled system edges carry the scan-side level onto the system copy.
  chk_sys_follow: assert property (
    @(posedge clock) disable iff (rst)
    clock_en [*3] |-> sys_test_mode == $past(test_mode, 2))
    else $error("system mode does not follow");

  chk_sys_highz: assert property (
    @(posedge clock) disable iff (rst)
    clock_en [*3] |-> sys_io_highz == $past(io_highz, 2))
    else $error("system high impedance does not follow");

  chk_sample_normal: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    active_instr == OPC_SAMPLE_BOUNDARY |->
      data_select == SEL_BOUNDARY && boundary_capture == CAP_SAMPLE && !test_mode)
    else $error("sample boundary decode wrong");

  chk_clamp_drive: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    active_instr == OPC_CLAMP_BOUNDARY |->
      data_select == SEL_BYPASS && test_mode && !io_highz)
    else $error("clamp decode wrong");

  chk_read_hold: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    (active_instr == OPC_READ_NORMAL || active_instr == OPC_READ_TEST) |->
      data_select == SEL_BOUNDARY && boundary_capture == CAP_HOLD &&
      test_mode == (active_instr == OPC_READ_TEST))
    else $error("boundary read decode wrong");

  chk_self_invert: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    active_instr == OPC_CELL_SELF_TEST |->
      data_select == SEL_BOUNDARY && boundary_capture == CAP_INVERT && !test_mode)
    else $error("self test decode wrong");

  chk_control_select: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    (active_instr == OPC_CONTROL_SCAN_NORMAL || active_instr == OPC_CONTROL_SCAN_TEST) |->
      data_select == SEL_CONTROL && test_mode == (active_instr == OPC_CONTROL_SCAN_TEST))
    else $error("run select scan decode wrong");

  chk_toggle_gate: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    toggle_active |-> run_idle && test_mode && active_instr == OPC_TOGGLE_OUTPUTS)
    else $error("toggle outside its instruction");

  chk_run_count: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    run_active && run_select_register == 3'h7 |-> run_op == RUN_SIG_COUNT)
    else $error("signature with count not decoded");

  chk_run_toggle: assert property (
    @(posedge tck) disable iff (test_logic_reset)
    run_active && run_select_register[1:0] == 2'h0 |-> run_op == RUN_TOGGLE_SAMPLE)
    else $error("toggle and sample not decoded");

  cov_boundary_scan: cover property (
    @(posedge tck) disable iff (test_logic_reset)
    active_instr == OPC_BOUNDARY_SCAN && capture_dr);

  cov_run_active: cover property (
    @(posedge tck) disable iff (test_logic_reset)
    run_active ##1 run_active);

  cov_toggle: cover property (
    @(posedge tck) disable iff (test_logic_reset)
    toggle_active);

  cov_control_scan: cover property (
    @(posedge tck) disable iff (test_logic_reset)
    data_select == SEL_CONTROL && shift_dr);

  cov_self_test: cover property (
    @(posedge tck) disable iff (test_logic_reset)
    boundary_capture == CAP_INVERT && capture_dr);

endmodule : sid_scan_instruction_decoder
